// ---- command_packet_fetch_parse_test.sv ----
`default_nettype none
module command_packet_fetch_parse_test;
  timeunit 1ns;
  timeprecision 1ns;
  // Design ports
  logic MCLK, RST, POLL_RD, OUT_READY, POLL_ACK, BUSY;
  logic MEM_REQ, MEM_MAIN, MEM_RVALID, OUT_VALID;
  logic [14:0] POLL_ADDR;
  logic [31:0] POLL_DATA, MEM_RDATA, OUT_DATA, CTX_DATA;
  logic [25:0] MEM_ADDR;
  logic [4:0] OUT_SECTION;
  logic [3:0] CTX_SEL;
  int failures = 0;
  int n_tests = 0;
  // Expected word and section for each output slot
  logic [31:0] exp_data [0:45];
  cpf_pkg::cpf_sec_t exp_sec [0:45];

  cpf_fetch_parse i_cpf_fetch_parse (.MCLK(MCLK), .RST(RST), .POLL_RD(POLL_RD),
    .POLL_ADDR(POLL_ADDR), .POLL_ACK(POLL_ACK), .POLL_DATA(POLL_DATA), .BUSY(BUSY),
    .MEM_REQ(MEM_REQ), .MEM_MAIN(MEM_MAIN), .MEM_ADDR(MEM_ADDR), .MEM_RVALID(MEM_RVALID),
    .MEM_RDATA(MEM_RDATA), .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY),
    .OUT_DATA(OUT_DATA), .OUT_SECTION(OUT_SECTION), .CTX_SEL(CTX_SEL), .CTX_DATA(CTX_DATA));
  cpf_mem_model i_cpf_mem_model (.MCLK(MCLK), .RST(RST), .MEM_REQ(MEM_REQ),
    .MEM_ADDR(MEM_ADDR), .MEM_RVALID(MEM_RVALID), .MEM_RDATA(MEM_RDATA));

  // Clock generator
  initial
  begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end

  // Compares one value and reports a mismatch
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_tests++;
    if (seen !== want)
    begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check

  // Prints the verdict and ends the run
  task automatic finish_test;
    if (failures == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test

  // Moves to just after the next rising edge
  task automatic tick;
    @(posedge MCLK);
    #1;
  endtask : tick

  // One polling read, answer checked in the following cycle
  task automatic poll(input logic [14:0] addr, input logic [31:0] want);
    POLL_RD = 1'b1;
    POLL_ADDR = addr;
    tick();
    POLL_RD = 1'b0;
    check({31'h0, POLL_ACK}, 32'h1);
    check(POLL_DATA, want);
  endtask : poll

  // Drains the stream with an early stall, optionally polling mid-stream
  task automatic run_stream(input logic mid_poll);
    int k;
    int n;
    logic rdy;
    k = 0;
    for (n = 0; n < 2000 && k < 46; n++)
    begin
      rdy = (n > 30) && (n % 3 != 0);
      OUT_READY = rdy;
      // Buffer full: word waiting, no fetch in flight
      if (n == 30)
        check({30'h0, OUT_VALID, MEM_REQ}, 32'h2);
      if (mid_poll && n == 40)
        POLL_RD = 1'b1;
      if (mid_poll && n == 41)
      begin
        POLL_RD = 1'b0;
        check(POLL_DATA, cpf_pkg::STAT_BUSY);
      end
      if (OUT_VALID === 1'b1 && rdy)
      begin
        check(OUT_DATA, exp_data[k]);
        check({27'h0, OUT_SECTION}, {27'h0, exp_sec[k]});
        k++;
      end
      tick();
    end
    OUT_READY = 1'b1;
    if (k < 46)
    begin
      failures++;
      finish_test();
    end
    for (n = 0; n < 50 && BUSY !== 1'b0; n++)
      tick();
    check({30'h0, BUSY, OUT_VALID}, 32'h0);
  endtask : run_stream

  // Main sequence
  initial
  begin
    RST = 1'b1;
    POLL_RD = 1'b0;
    POLL_ADDR = 15'h0;
    OUT_READY = 1'b0;
    CTX_SEL = 4'h0;
    // Aligned packet, three ids, fifteen instructions, chained to a bare header
    for (int i = 0; i < 46; i++)
    begin
      exp_data[i] = 32'ha000_0000 | i;
      exp_sec[i] = (i < 1 || i == 45) ? cpf_pkg::SEC_HDR : i < 4 ? cpf_pkg::SEC_PID :
        i < 19 ? cpf_pkg::SEC_INST : i < 21 ? cpf_pkg::SEC_PKT :
        (i - 21) % 12 < 8 ? cpf_pkg::SEC_PRIM + 5'h01 :
        (i - 21) % 12 < 10 ? cpf_pkg::SEC_VTX : cpf_pkg::SEC_DATA;
    end
    exp_data[0] = 32'h02fc_0c91;
    exp_data[45] = 32'h0000_0001;
    for (int i = 0; i < 46; i++)
      i_cpf_mem_model.mem[i] = exp_data[i];
    i_cpf_mem_model.mem[46] = 32'h0;
    repeat (20) tick();
    RST = 1'b0;
    check(CTX_DATA, 32'h0);
    tick();
    poll(15'h0000, cpf_pkg::STAT_FREE);
    check({5'h0, MEM_MAIN, MEM_ADDR}, 32'h0);
    check({31'h0, BUSY}, 32'h1);
    run_stream(1'b1);
    // Clip words survive the chained packet that omits them
    CTX_SEL = 4'h0;
    tick();
    check(CTX_DATA, exp_data[19]);
    CTX_SEL = 4'h1;
    tick();
    check(CTX_DATA, exp_data[20]);
    poll(15'h4001, cpf_pkg::STAT_FREE);
    check({5'h0, MEM_MAIN, MEM_ADDR}, {5'h0, 1'b1, 26'h000_1000});
    run_stream(1'b0);
    finish_test();
  end
endmodule : command_packet_fetch_parse_test
`default_nettype wire

// ---- cpf_fetch_parse.sv ----
// Functional notes
// - Polling read address carries packet base
// - Status returned in same polling read
// - Base 26:12 from address 17:3
// - Bit 26 selects main or scratch
// - First fetched word is header
// - Rendering program follows header directly
// - At most three map identifiers
// - At most fifteen program instructions
// - Packet, primitive, vertex context levels
// - Packet context persists across chained packets
// - XY mask is eight words
// - Fixed context order within each level
// - Primitive section repeats per primitive
// - Zero word stops, nonzero is header
// - Free reads zero, busy reads 0x00800000
`default_nettype none
module cpf_fetch_parse (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic POLL_RD,
  input wire logic [14:0] POLL_ADDR,
  output logic POLL_ACK,
  output logic [31:0] POLL_DATA,
  output logic BUSY,
  output logic MEM_REQ,
  output logic MEM_MAIN,
  output logic [25:0] MEM_ADDR,
  input wire logic MEM_RVALID,
  input wire logic [31:0] MEM_RDATA,
  output logic OUT_VALID,
  input wire logic OUT_READY,
  output logic [31:0] OUT_DATA,
  output logic [4:0] OUT_SECTION,
  input wire logic [3:0] CTX_SEL,
  output logic [31:0] CTX_DATA
);

  // Whole block state
  typedef struct packed {
    cpf_pkg::cpf_state_t fsm;
    cpf_pkg::cpf_sec_t sec;
    logic [3:0] left;
    logic [7:0] prim_left;
    logic [31:0] hdr;
    logic [25:0] addr;
    logic main_sel;
    logic poll_ack;
    logic [31:0] poll_data;
    logic [1:0][31:0] buf_word;
    logic [1:0][4:0] buf_tag;
    logic buf_rd;
    logic [1:0] buf_cnt;
    logic [14:0][31:0] ctx;
    logic [31:0] ctx_out;
  } cpf_regs_t;

  cpf_regs_t state_reg;
  cpf_regs_t state_next;

  // Words held by a context element
  function automatic logic [3:0] elem_len(input logic [2:0] e);
    if (e == cpf_pkg::ELEM_CLIP)
      elem_len = cpf_pkg::CLIP_WORDS;
    else if (e == cpf_pkg::ELEM_XY)
      elem_len = cpf_pkg::XY_WORDS;
    else
      elem_len = cpf_pkg::ONE_WORD;
  endfunction : elem_len

  // Format field of a context element
  function automatic logic [1:0] elem_fmt(input logic [31:0] h, input logic [2:0] e);
    elem_fmt = h[cpf_pkg::FMT_LSB + 2 * e +: 2];
  endfunction : elem_fmt

  // Vertices per primitive by geometry format
  function automatic logic [3:0] vtx_count(input logic [2:0] g);
    case (g)
      3'h0: vtx_count = 4'h1;
      3'h3: vtx_count = 4'h4;
      3'h4, 3'h5: vtx_count = 4'h0;
      default: vtx_count = 4'h2;
    endcase
  endfunction : vtx_count

  // Vertex data words per primitive
  function automatic logic [3:0] data_words(input logic [2:0] g);
    case (g)
      3'h0: data_words = 4'h1;
      3'h1: data_words = 4'h2;
      3'h3: data_words = 4'h4;
      3'h4, 3'h5: data_words = 4'h5;
      default: data_words = 4'h3;
    endcase
  endfunction : data_words

  // Length of a section for the current header, zero when absent
  function automatic logic [3:0] sec_len(input logic [4:0] s, input logic [31:0] h);
    logic [2:0] e;
    e = 3'h0;
    sec_len = 4'h0;
    if (s == cpf_pkg::SEC_HDR)
      sec_len = cpf_pkg::ONE_WORD;
    else if (s == cpf_pkg::SEC_PID)
      sec_len = {2'h0, h[cpf_pkg::PID_LSB +: 2]};
    else if (s == cpf_pkg::SEC_INST)
      sec_len = h[cpf_pkg::INST_LSB +: 4];
    else if (s < cpf_pkg::SEC_PRIM)
    begin
      e = 3'(s - cpf_pkg::SEC_PKT);
      sec_len = (elem_fmt(h, e) == cpf_pkg::FMT_PKT) ? elem_len(e) : 4'h0;
    end
    else if (s < cpf_pkg::SEC_VTX)
    begin
      e = 3'(s - cpf_pkg::SEC_PRIM);
      sec_len = (elem_fmt(h, e) == cpf_pkg::FMT_PRIM) ? elem_len(e) : 4'h0;
    end
    else if (s < cpf_pkg::SEC_DATA)
    begin
      e = 3'(s - cpf_pkg::SEC_VTX) + cpf_pkg::FIRST_PLANE;
      sec_len = (elem_fmt(h, e) == cpf_pkg::FMT_VERT) ? vtx_count(h[2:0]) : 4'h0;
    end
    else
      sec_len = data_words(h[2:0]);
  endfunction : sec_len

  // First stored word of a per-packet element
  function automatic logic [3:0] ctx_base(input logic [2:0] e);
    if (e == cpf_pkg::ELEM_CLIP)
      ctx_base = 4'h0;
    else if (e == cpf_pkg::ELEM_XY)
      ctx_base = cpf_pkg::CLIP_WORDS;
    else
      ctx_base = {1'b0, e} + cpf_pkg::CLIP_WORDS + cpf_pkg::XY_WORDS - 4'h2;
  endfunction : ctx_base

  logic push;
  logic pop;

  // Sequencer, buffer and context next state
  always_comb
  begin
    logic step;
    logic [3:0] len;
    logic [2:0] e;
    logic [3:0] idx;
    step = 1'b0;
    len = sec_len(state_reg.sec, state_reg.hdr);
    e = 3'(state_reg.sec - cpf_pkg::SEC_PKT);
    idx = ctx_base(e) + elem_len(e) - state_reg.left;
    state_next = state_reg;
    state_next.poll_ack = 1'b0;
    pop = OUT_READY && (state_reg.buf_cnt != 2'h0);
    push = 1'b0;
    // Polling read: status and base in one answer
    if (POLL_RD)
    begin
      state_next.poll_ack = 1'b1;
      if (state_reg.fsm == cpf_pkg::ST_IDLE)
      begin
        state_next.poll_data = cpf_pkg::STAT_FREE;
        state_next.main_sel = POLL_ADDR[cpf_pkg::MAIN_BIT];
        state_next.addr = {POLL_ADDR[cpf_pkg::MAIN_BIT-1:0], 12'h000};
        state_next.sec = cpf_pkg::SEC_HDR;
        state_next.fsm = cpf_pkg::ST_SEEK;
      end
      else
        state_next.poll_data = cpf_pkg::STAT_BUSY;
    end
    case (state_reg.fsm)
      // Find next present section
      cpf_pkg::ST_SEEK:
      begin
        if (len != 4'h0)
        begin
          state_next.left = len;
          state_next.fsm = cpf_pkg::ST_FETCH;
        end
        else
          step = 1'b1;
      end
      // Wait for buffer room before reading
      cpf_pkg::ST_FETCH:
      begin
        if (state_reg.buf_cnt != 2'h2)
          state_next.fsm = cpf_pkg::ST_WAIT;
      end
      // Word returned from packet memory
      cpf_pkg::ST_WAIT:
      begin
        if (MEM_RVALID)
        begin
          state_next.addr = state_reg.addr + cpf_pkg::WORD_STEP;
          if (state_reg.sec == cpf_pkg::SEC_HDR && MEM_RDATA == 32'h0)
            state_next.fsm = cpf_pkg::ST_IDLE;
          else
          begin
            push = 1'b1;
            if (state_reg.sec == cpf_pkg::SEC_HDR)
            begin
              state_next.hdr = MEM_RDATA;
              state_next.prim_left = MEM_RDATA[cpf_pkg::PRIM_LSB +: 8];
            end
            if (state_reg.sec >= cpf_pkg::SEC_PKT && state_reg.sec < cpf_pkg::SEC_PRIM)
              state_next.ctx[idx] = MEM_RDATA;
            state_next.left = state_reg.left - 4'h1;
            if (state_reg.left == 4'h1)
              step = 1'b1;
            else
              state_next.fsm = cpf_pkg::ST_FETCH;
          end
        end
      end
      default: ;
    endcase
    // Advance to the following section in fixed order
    if (step)
    begin
      state_next.fsm = cpf_pkg::ST_SEEK;
      if (state_reg.sec == cpf_pkg::SEC_DATA)
      begin
        if (state_reg.prim_left > 8'h1)
        begin
          state_next.prim_left = state_reg.prim_left - 8'h1;
          state_next.sec = cpf_pkg::SEC_PRIM;
        end
        else
        begin
          state_next.prim_left = 8'h0;
          state_next.sec = cpf_pkg::SEC_HDR;
        end
      end
      else if (state_reg.sec == cpf_pkg::SEC_PRIM - 5'h1 && state_next.prim_left == 8'h0)
        state_next.sec = cpf_pkg::SEC_HDR;
      else
        state_next.sec = state_reg.sec + 5'h1;
    end
    // Two-entry output buffer
    if (push)
    begin
      state_next.buf_word[state_reg.buf_rd ^ state_reg.buf_cnt[0]] = MEM_RDATA;
      state_next.buf_tag[state_reg.buf_rd ^ state_reg.buf_cnt[0]] = state_reg.sec;
    end
    if (pop)
      state_next.buf_rd = ~state_reg.buf_rd;
    state_next.buf_cnt = state_reg.buf_cnt + {1'b0, push} - {1'b0, pop};
    // Held packet context readback
    state_next.ctx_out = (int'(CTX_SEL) < cpf_pkg::CTX_WORDS) ? state_reg.ctx[CTX_SEL] : 32'h0;
  end

  // State register
  always_ff @(posedge MCLK)
  begin
    if (RST)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  // Port drive
  assign POLL_ACK = state_reg.poll_ack;
  assign POLL_DATA = state_reg.poll_data;
  assign BUSY = (state_reg.fsm != cpf_pkg::ST_IDLE);
  assign MEM_REQ = (state_reg.fsm == cpf_pkg::ST_WAIT);
  assign MEM_MAIN = state_reg.main_sel;
  assign MEM_ADDR = state_reg.addr;
  assign OUT_VALID = (state_reg.buf_cnt != 2'h0);
  assign OUT_DATA = state_reg.buf_word[state_reg.buf_rd];
  assign OUT_SECTION = state_reg.buf_tag[state_reg.buf_rd];
  assign CTX_DATA = state_reg.ctx_out;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  logic take;
  assign take = POLL_RD && state_reg.fsm == cpf_pkg::ST_IDLE;

  property p_poll_answer;
    POLL_RD |=> POLL_ACK;
  endproperty
  a_poll_answer: assert property (p_poll_answer) else $error("poll not answered");

  property p_busy_code;
    POLL_RD && BUSY |=> POLL_DATA == cpf_pkg::STAT_BUSY && POLL_ACK;
  endproperty
  a_busy_code: assert property (p_busy_code) else $error("busy poll wrong");

  property p_base_form;
    take |=> POLL_DATA == cpf_pkg::STAT_FREE && MEM_ADDR[cpf_pkg::ALIGN_BITS-1:0] == 12'h0
      && MEM_ADDR[25:12] == $past(POLL_ADDR[13:0]);
  endproperty
  a_base_form: assert property (p_base_form) else $error("packet base wrong");

  property p_main_sel;
    take |=> MEM_MAIN == $past(POLL_ADDR[cpf_pkg::MAIN_BIT]) ##1 !MEM_REQ;
  endproperty
  a_main_sel: assert property (p_main_sel) else $error("memory select wrong");

  property p_first_hdr;
    take |=> state_reg.sec == cpf_pkg::SEC_HDR ##1 state_reg.fsm == cpf_pkg::ST_FETCH;
  endproperty
  a_first_hdr: assert property (p_first_hdr) else $error("header not first");

  property p_seq_fetch;
    MEM_REQ && MEM_RVALID |=> MEM_ADDR == $past(MEM_ADDR) + cpf_pkg::WORD_STEP;
  endproperty
  a_seq_fetch: assert property (p_seq_fetch) else $error("fetch not sequential");

  property p_prog_next;
    MEM_REQ && MEM_RVALID && state_reg.sec == cpf_pkg::SEC_HDR && MEM_RDATA != 32'h0
      |=> state_reg.sec == cpf_pkg::SEC_PID;
  endproperty
  a_prog_next: assert property (p_prog_next) else $error("program not after header");

  property p_stop_zero;
    MEM_REQ && MEM_RVALID && state_reg.sec == cpf_pkg::SEC_HDR && MEM_RDATA == 32'h0
      |=> !BUSY && state_reg.sec == cpf_pkg::SEC_HDR;
  endproperty
  a_stop_zero: assert property (p_stop_zero) else $error("zero word did not stop");

  property p_xy_len;
    state_reg.fsm == cpf_pkg::ST_SEEK
      && ((state_reg.sec == cpf_pkg::SEC_PKT + 5'h1
      && elem_fmt(state_reg.hdr, cpf_pkg::ELEM_XY) == cpf_pkg::FMT_PKT)
      || (state_reg.sec == cpf_pkg::SEC_PRIM + 5'h1
      && elem_fmt(state_reg.hdr, cpf_pkg::ELEM_XY) == cpf_pkg::FMT_PRIM))
      |=> state_reg.left == cpf_pkg::XY_WORDS;
  endproperty
  a_xy_len: assert property (p_xy_len) else $error("xy mask length wrong");

  property p_ctx_keep;
    take |=> $stable(state_reg.ctx);
  endproperty
  a_ctx_keep: assert property (p_ctx_keep) else $error("packet context lost");

endmodule : cpf_fetch_parse
`default_nettype wire

// ---- cpf_mem_model.sv ----
`default_nettype none
module cpf_mem_model (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic MEM_REQ,
  input wire logic [25:0] MEM_ADDR,
  output logic MEM_RVALID,
  output logic [31:0] MEM_RDATA
);
  timeunit 1ns;
  timeprecision 1ns;
  // Packet store, one word per index
  logic [31:0] mem [0:255];
  // Cycles still to wait before the next answer
  logic [1:0] wait_reg;
  // Alternates prompt and slow answers
  logic slow_reg;
  // One answer per request, then the data line keeps changing
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      MEM_RVALID <= 1'b0;
      wait_reg <= 2'h0;
      slow_reg <= 1'b0;
      MEM_RDATA <= 32'h0;
    end
    else if (MEM_REQ && !MEM_RVALID && wait_reg == 2'h0)
    begin
      MEM_RVALID <= 1'b1;
      MEM_RDATA <= mem[MEM_ADDR[9:2]];
      slow_reg <= !slow_reg;
      wait_reg <= slow_reg ? 2'h3 : 2'h0;
    end
    else
    begin
      // Released data line keeps changing
      MEM_RVALID <= 1'b0;
      MEM_RDATA <= ~MEM_RDATA;
      if (MEM_REQ && !MEM_RVALID)
        wait_reg <= wait_reg - 2'h1;
    end
  end
endmodule : cpf_mem_model
`default_nettype wire

// ---- cpf_pkg.sv ----
`default_nettype none
package cpf_pkg;
  // Polling address bits 17:3 carry packet base bits 26:12
  localparam int POLL_AW = 15;
  localparam int ALIGN_BITS = 12;
  localparam int MEM_AW = 26;
  localparam int MAIN_BIT = 14;
  localparam logic [25:0] WORD_STEP = 26'h4;
  // Polling read answers
  localparam logic [31:0] STAT_FREE = 32'h0;
  localparam logic [31:0] STAT_BUSY = 32'h0080_0000;
  // Header field positions
  localparam int FMT_LSB = 4;
  localparam int INST_LSB = 18;
  localparam int PID_LSB = 22;
  localparam int PRIM_LSB = 24;
  // Context element formats
  localparam logic [1:0] FMT_PKT = 2'h1;
  localparam logic [1:0] FMT_PRIM = 2'h2;
  localparam logic [1:0] FMT_VERT = 2'h3;
  // Context element sizes in words
  localparam logic [3:0] CLIP_WORDS = 4'h2;
  localparam logic [3:0] XY_WORDS = 4'h8;
  localparam logic [3:0] ONE_WORD = 4'h1;
  localparam int CTX_WORDS = 15;
  // Section codes, also tagged onto each output word
  typedef logic [4:0] cpf_sec_t;
  localparam cpf_sec_t SEC_HDR = 5'h00;
  localparam cpf_sec_t SEC_PID = 5'h01;
  localparam cpf_sec_t SEC_INST = 5'h02;
  localparam cpf_sec_t SEC_PKT = 5'h03;
  localparam cpf_sec_t SEC_PRIM = 5'h0a;
  localparam cpf_sec_t SEC_VTX = 5'h11;
  localparam cpf_sec_t SEC_DATA = 5'h15;
  localparam logic [2:0] ELEM_CLIP = 3'h0;
  localparam logic [2:0] ELEM_XY = 3'h1;
  localparam logic [2:0] FIRST_PLANE = 3'h3;
  // Sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_SEEK, ST_FETCH, ST_WAIT} cpf_state_t;
endpackage : cpf_pkg
`default_nettype wire
